//--- hdl/dme_params.svh
`ifndef DME_PARAMS_SVH
`define DME_PARAMS_SVH

// Clock rate and write cycle time
`define DME_REF_CLK_MHZ 100
`define DME_TWR_MS 10
`define DME_TWR_CYCLES (`DME_TWR_MS * 1000 * `DME_REF_CLK_MHZ)

// Transmit-only stream
`define DME_SYNC_CLOCKS 4'h9
`define DME_NULL_SLOT 4'h8
`define DME_TX_PTR_START 7'h00
// Link rises swallowed while the link-domain reset releases
`define DME_LINK_RST_RISES 4'h2

// Transition mode: last count before the 128th pulse
`define DME_TRANS_LAST 8'h7F

// Two-wire slave
`define DME_DEVICE_CODE 7'h50
`define DME_BYTE_BITS 4'h8
`define DME_MEM_BYTES 256
`define DME_PAGE_BYTES 8

`endif

//--- hdl/dme_pkg.sv
package dme_pkg;

    // Operating mode of the port
    typedef enum logic [1:0] {MODE_TX, MODE_TRANS, MODE_BIDIR} dme_mode_t;

    // Two-wire slave sequence
    typedef enum logic [3:0] {
        BUS_IDLE,
        BUS_ADDR,
        BUS_ADDR_ACK,
        BUS_WORD,
        BUS_WORD_ACK,
        BUS_DATA,
        BUS_DATA_ACK,
        BUS_SEND,
        BUS_SEND_ACK
    } dme_bus_t;

endpackage

//--- hdl/dme_port.sv
// What this block does
// - Power up streaming, pointer at location zero
// - Stream bits on transmit-only clock rise
// - Eight bits MSB first, then null slot
// - Sequential bytes, wrap after 7Fh to zero
// - Nine sync clocks, data line released
// - Tenth clock rise sends MSB of zero
// - Bus clock fall enters transition, counts
// - Bus clock fall clears pulse count
// - 128 idle pulses return to streaming
// - Control byte locks bidirectional mode forever
// - Ignore stream clock; writes need it high
// - Full array bidirectional, lower half streaming
// - Data change during clock high is condition
// - Start is data fall, clock high
// - Stop is data rise, ends operation
// - Keep last eight written bytes, address wraps in page
// - Receiver holds ack low ninth pulse
// - Release data after master withholds ack
// - Seven bit device code, then direction
// - Ack address only when idle, matching
// - Internal write cycle ends within 10 ms
`timescale 1ns/1ps
`include "dme_params.svh"

module dme_port #(
    parameter int unsigned WRITE_CYCLES = `DME_TWR_CYCLES
)(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    input wire logic transmitOnlyClock,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic bidirMode,
    output logic writeBusy
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic linkRstMeta_q;
    logic linkRstSync_q;
    logic linkTog_q;
    logic togMeta_q, togSync_q, togPrev_q;
    logic lvlMeta_q, lvlSync_q;
    logic sclMeta_q, sclSync_q, sclPrev_q;
    logic sdaMeta_q, sdaSync_q, sdaPrev_q;
    dme_pkg::dme_mode_t mode_q;
    logic [7:0] transCnt_q;
    logic [3:0] initCnt_q;
    logic [6:0] txPtr_q;
    logic [3:0] txBit_q;
    logic streamLow_q;
    dme_pkg::dme_bus_t state_q;
    logic [3:0] bitCnt_q;
    logic [7:0] shReg_q;
    logic [7:0] slvPtr_q;
    logic [7:0] txByte_q;
    logic slaveLow_q;
    logic ackSeen_q;
    logic wrActive_q;
    logic wpBlock_q;
    logic [7:0] pageValid_q;
    logic [7:0] pageBuf_q [0:`DME_PAGE_BYTES-1];
    logic [7:0] mem_q [0:`DME_MEM_BYTES-1];
    logic busy_q;
    logic [19:0] busyCnt_q;

    // Bit of a byte, most significant first
    function automatic logic msbFirst(input logic [7:0] b, input logic [2:0] idx);
        msbFirst = b[3'h7 - idx];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: one toggle per transmit-only clock rise

    // Reset crosses into the link domain; the first two rises after release
    // are spent here, so the core counts them as sync clocks up front
    always_ff @(posedge transmitOnlyClock)
    begin
        linkRstMeta_q <= reset_n;
        linkRstSync_q <= linkRstMeta_q;
    end

    // Toggle carries each rising edge as an event to the core
    always_ff @(posedge transmitOnlyClock)
    begin
        if (!linkRstSync_q)
            linkTog_q <= 1'b0;
        else
            linkTog_q <= ~linkTog_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core domain synchronisers

    // Two flops per foreign input; edges compare the second stage with a third
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            {togMeta_q, togSync_q, togPrev_q} <= 3'h0;
            {lvlMeta_q, lvlSync_q} <= 2'h0;
            {sclMeta_q, sclSync_q, sclPrev_q} <= 3'h7;
            {sdaMeta_q, sdaSync_q, sdaPrev_q} <= 3'h7;
        end
        else if (clkEn)
        begin
            {togMeta_q, togSync_q, togPrev_q} <= {linkTog_q, togMeta_q, togSync_q};
            {lvlMeta_q, lvlSync_q} <= {transmitOnlyClock, lvlMeta_q};
            {sclMeta_q, sclSync_q, sclPrev_q} <= {sclIn, sclMeta_q, sclSync_q};
            {sdaMeta_q, sdaSync_q, sdaPrev_q} <= {sdaIn, sdaMeta_q, sdaSync_q};
        end
    end

    // Edge and bus condition decode
    wire txRise = togSync_q ^ togPrev_q;
    wire sclRise = sclSync_q & ~sclPrev_q;
    wire sclFall = ~sclSync_q & sclPrev_q;
    wire sclHeld = sclSync_q & sclPrev_q;
    wire startCond = sclHeld & sdaPrev_q & ~sdaSync_q;
    wire stopCond = sclHeld & ~sdaPrev_q & sdaSync_q;
    wire byteDone = sclFall && (bitCnt_q == `DME_BYTE_BITS);
    wire addrHit = (shReg_q[7:1] == `DME_DEVICE_CODE) && !busy_q;
    wire addrAccept = (state_q == dme_pkg::BUS_ADDR) && byteDone && addrHit;
    wire isTx = (mode_q == dme_pkg::MODE_TX);
    wire streamOn = (initCnt_q == `DME_SYNC_CLOCKS);
    wire [7:0] streamByte = mem_q[{1'b0, txPtr_q}];
    wire [7:0] slaveByte = mem_q[slvPtr_q];
    wire commit = stopCond && wrActive_q && !wpBlock_q && (pageValid_q != 8'h00);

    ////////////////////////////////////////////////////////////////////////////
    // Mode control

    // Only power loss (reset) leaves the bidirectional mode
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            mode_q <= dme_pkg::MODE_TX;
            transCnt_q <= 8'h00;
        end
        else if (clkEn)
        begin
            case (mode_q)
                dme_pkg::MODE_TX:
                begin
                    if (sclFall)
                    begin
                        mode_q <= dme_pkg::MODE_TRANS;
                        transCnt_q <= 8'h00;
                    end
                end
                dme_pkg::MODE_TRANS:
                begin
                    if (addrAccept)
                        mode_q <= dme_pkg::MODE_BIDIR;
                    else if (sclFall)
                        transCnt_q <= 8'h00;
                    else if (txRise && sclSync_q)
                    begin
                        if (transCnt_q == `DME_TRANS_LAST)
                        begin
                            mode_q <= dme_pkg::MODE_TX;
                            transCnt_q <= 8'h00;
                        end
                        else
                            transCnt_q <= transCnt_q + 8'h01;
                    end
                end
                dme_pkg::MODE_BIDIR:
                    mode_q <= dme_pkg::MODE_BIDIR;
                default:
                    mode_q <= dme_pkg::MODE_TX;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit-only stream

    // Pointer and bit slot restart whenever streaming is off, so a return
    // from transition resumes at the top bit of location zero
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            initCnt_q <= `DME_LINK_RST_RISES;
            txPtr_q <= `DME_TX_PTR_START;
            txBit_q <= 4'h0;
            streamLow_q <= 1'b0;
        end
        else if (clkEn)
        begin
            if (!isTx)
            begin
                txPtr_q <= `DME_TX_PTR_START;
                txBit_q <= 4'h0;
                streamLow_q <= 1'b0;
            end
            else if (txRise && !streamOn)
            begin
                initCnt_q <= initCnt_q + 4'h1;
                streamLow_q <= 1'b0;
            end
            else if (txRise && (txBit_q == `DME_NULL_SLOT))
            begin
                streamLow_q <= 1'b0;
                txBit_q <= 4'h0;
                txPtr_q <= txPtr_q + 7'h01;
            end
            else if (txRise)
            begin
                streamLow_q <= !msbFirst(streamByte, txBit_q[2:0]);
                txBit_q <= txBit_q + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-wire slave

    // Data changes only after a bus clock fall, so no false conditions
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            state_q <= dme_pkg::BUS_IDLE;
            bitCnt_q <= 4'h0;
            shReg_q <= 8'h00;
            slvPtr_q <= 8'h00;
            txByte_q <= 8'h00;
            slaveLow_q <= 1'b0;
            ackSeen_q <= 1'b0;
            wrActive_q <= 1'b0;
            pageValid_q <= 8'h00;
        end
        else if (clkEn)
        begin
            if (isTx)
            begin
                state_q <= dme_pkg::BUS_IDLE;
                slaveLow_q <= 1'b0;
            end
            else if (startCond)
            begin
                state_q <= dme_pkg::BUS_ADDR;
                bitCnt_q <= 4'h0;
                slaveLow_q <= 1'b0;
            end
            else if (stopCond)
            begin
                state_q <= dme_pkg::BUS_IDLE;
                slaveLow_q <= 1'b0;
                wrActive_q <= 1'b0;
                pageValid_q <= 8'h00;
            end
            else
            begin
                case (state_q)
                    dme_pkg::BUS_ADDR, dme_pkg::BUS_WORD, dme_pkg::BUS_DATA:
                    begin
                        if (sclRise)
                        begin
                            shReg_q <= {shReg_q[6:0], sdaSync_q};
                            bitCnt_q <= bitCnt_q + 4'h1;
                        end
                        else if (byteDone)
                        begin
                            bitCnt_q <= 4'h0;
                            slaveLow_q <= 1'b1;
                            if (state_q == dme_pkg::BUS_ADDR)
                            begin
                                state_q <= addrHit ? dme_pkg::BUS_ADDR_ACK
                                                   : dme_pkg::BUS_IDLE;
                                slaveLow_q <= addrHit;
                                wrActive_q <= addrHit && !shReg_q[0];
                                pageValid_q <= 8'h00;
                            end
                            else if (state_q == dme_pkg::BUS_WORD)
                            begin
                                slvPtr_q <= shReg_q;
                                state_q <= dme_pkg::BUS_WORD_ACK;
                            end
                            else
                            begin
                                pageBuf_q[slvPtr_q[2:0]] <= shReg_q;
                                pageValid_q[slvPtr_q[2:0]] <= 1'b1;
                                slvPtr_q[2:0] <= slvPtr_q[2:0] + 3'h1;
                                state_q <= dme_pkg::BUS_DATA_ACK;
                            end
                        end
                    end
                    dme_pkg::BUS_ADDR_ACK, dme_pkg::BUS_SEND_ACK:
                    begin
                        if (sclRise)
                            ackSeen_q <= !sdaSync_q;
                        else if (sclFall && wrActive_q)
                        begin
                            state_q <= dme_pkg::BUS_WORD;
                            slaveLow_q <= 1'b0;
                        end
                        else if (sclFall && (state_q == dme_pkg::BUS_SEND_ACK) && !ackSeen_q)
                        begin
                            state_q <= dme_pkg::BUS_IDLE;
                            slaveLow_q <= 1'b0;
                        end
                        else if (sclFall)
                        begin
                            txByte_q <= slaveByte;
                            slaveLow_q <= !msbFirst(slaveByte, 3'h0);
                            bitCnt_q <= 4'h1;
                            slvPtr_q <= slvPtr_q + 8'h01;
                            state_q <= dme_pkg::BUS_SEND;
                        end
                    end
                    dme_pkg::BUS_WORD_ACK, dme_pkg::BUS_DATA_ACK:
                    begin
                        if (sclFall)
                        begin
                            state_q <= dme_pkg::BUS_DATA;
                            slaveLow_q <= 1'b0;
                        end
                    end
                    dme_pkg::BUS_SEND:
                    begin
                        if (byteDone)
                        begin
                            slaveLow_q <= 1'b0;
                            state_q <= dme_pkg::BUS_SEND_ACK;
                        end
                        else if (sclFall)
                        begin
                            slaveLow_q <= !msbFirst(txByte_q, bitCnt_q[2:0]);
                            bitCnt_q <= bitCnt_q + 4'h1;
                        end
                    end
                    default:
                        state_q <= dme_pkg::BUS_IDLE;
                endcase
            end
        end
    end

    // Write protect: a low transmit-only clock level anywhere after the write control byte
    // spoils the write; set wins over the clear of a new address
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            wpBlock_q <= 1'b0;
        else if (clkEn)
        begin
            if (wrActive_q && !lvlSync_q)
                wpBlock_q <= 1'b1;
            else if (addrAccept)
                wpBlock_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array and write cycle

    // Page is committed at the stop; the timer then only blocks acks
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < `DME_MEM_BYTES; i++)
                mem_q[i] <= 8'h00;
        end
        else if (clkEn && commit)
        begin
            for (int i = 0; i < `DME_PAGE_BYTES; i++)
                if (pageValid_q[i])
                    mem_q[{slvPtr_q[7:3], 3'(i)}] <= pageBuf_q[i];
        end
    end

    // Busy timer for the internal write cycle
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            busy_q <= 1'b0;
            busyCnt_q <= 20'h00000;
        end
        else if (clkEn)
        begin
            if (commit)
            begin
                busy_q <= 1'b1;
                busyCnt_q <= 20'h00000;
            end
            else if (busy_q && (busyCnt_q == 20'(WRITE_CYCLES - 1)))
                busy_q <= 1'b0;
            else if (busy_q)
                busyCnt_q <= busyCnt_q + 20'h00001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Open drain: the pin is only ever pulled low
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            sdaOut <= 1'b0;
            sdaOe <= 1'b0;
            bidirMode <= 1'b0;
            writeBusy <= 1'b0;
        end
        else if (clkEn)
        begin
            sdaOut <= 1'b0;
            sdaOe <= isTx ? streamLow_q : slaveLow_q;
            bidirMode <= (mode_q == dme_pkg::MODE_BIDIR);
            writeBusy <= busy_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    a_sync_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (isTx && !streamOn) |-> !streamLow_q)
        else $error("Data line driven during sync clocks");

    a_null_release: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (isTx && $changed(txPtr_q)) |-> !streamLow_q)
        else $error("Data line driven in null slot");

    a_ptr_wrap: assert property (@(posedge ref_clk) disable iff (!reset_n)
        $changed(txPtr_q) |-> (txPtr_q == $past(txPtr_q) + 7'h01) || (txPtr_q == 7'h00))
        else $error("Stream pointer skipped");

    a_bidir_lock: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (mode_q == dme_pkg::MODE_BIDIR) |=> (mode_q == dme_pkg::MODE_BIDIR))
        else $error("Left bidirectional mode");

    a_trans_return: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clkEn && mode_q == dme_pkg::MODE_TRANS && transCnt_q == 8'h7F && txRise
         && sclSync_q && !sclFall && !addrAccept) |=> isTx ##1 (txPtr_q == 7'h00))
        else $error("No return after 128 pulses");

    a_fall_clear: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clkEn && mode_q == dme_pkg::MODE_TRANS && sclFall && !addrAccept)
        |=> (transCnt_q == 8'h00))
        else $error("Pulse count not cleared");

    a_ack_busy: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_q == dme_pkg::BUS_ADDR_ACK && $changed(state_q)) |-> !$past(busy_q))
        else $error("Address acked while busy");

    a_ack_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (state_q == dme_pkg::BUS_WORD_ACK && sclHeld) |-> slaveLow_q && sdaOe)
        else $error("Ack not held low");

    a_start_addr: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clkEn && !isTx && startCond) |=> (state_q == dme_pkg::BUS_ADDR) && (bitCnt_q == 4'h0))
        else $error("Start not taken");

    a_stop_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clkEn && !isTx && stopCond && !startCond) |=> (state_q == dme_pkg::BUS_IDLE)
        ##1 !sdaOe)
        else $error("Stop did not end operation");

    a_busy_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (clkEn && commit) |=> busy_q [*2] ##1 (busyCnt_q != 20'h00000))
        else $error("Write cycle timer stalled");

endmodule

//--- verification/dme_host_model.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////
// Display host: two-wire bus master and source of the sync clock
module dme_host_model #(
    parameter int HALF = 8
)(
    input wire logic ref_clk,
    input wire logic sdaLine,
    output logic sclLine,
    output logic sdaLow,
    output logic transmitOnlyClock
);
    // Bus clock idles high so the port keeps streaming
    initial
    begin
        sclLine = 1'b1;
        sdaLow = 1'b0;
        transmitOnlyClock = 1'b0;
    end

    task automatic wait_half();
        repeat (HALF) @(posedge ref_clk);
    endtask

    // Sync clock runs only in bursts; started on a core edge, the odd offset keeps rises off core edges
    task automatic pulse_sync(input int n);
        #3;
        repeat (n)
        begin
            #24 transmitOnlyClock = 1'b1;
            #24 transmitOnlyClock = 1'b0;
        end
    endtask

    // Level alone matters once the port is locked in two-wire mode
    task automatic set_sync(input logic b);
        @(posedge ref_clk) transmitOnlyClock <= b;
    endtask

    // A lone bus clock fall moves the port out of streaming
    task automatic wake();
        @(posedge ref_clk) sclLine <= 1'b0;
        wait_half();
        sclLine <= 1'b1;
        wait_half();
    endtask

    // Bus idle first, then data falls while the clock is high
    task automatic start_cond();
        @(posedge ref_clk) sdaLow <= 1'b0;
        wait_half();
        sclLine <= 1'b1;
        wait_half();
        sdaLow <= 1'b1;
        wait_half();
        sclLine <= 1'b0;
        wait_half();
    endtask

    task automatic stop_cond();
        @(posedge ref_clk) sdaLow <= 1'b1;
        wait_half();
        sclLine <= 1'b1;
        wait_half();
        sdaLow <= 1'b0;
        wait_half();
    endtask

    // Data moves only while the clock is low; sampled half a cycle early
    task automatic bit_x(input logic b, output logic r);
        @(posedge ref_clk) sdaLow <= !b;
        wait_half();
        sclLine <= 1'b1;
        repeat (HALF) @(negedge ref_clk);
        r = sdaLine;
        @(posedge ref_clk) sclLine <= 1'b0;
        wait_half();
    endtask

    // Ninth clock is the master's extra pulse for the acknowledge
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        int i;
        for (i = 7; i >= 0; i--)
            bit_x(b[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask

    // Last byte of a read is left unacknowledged
    task automatic recv_byte(input logic ackIt, output logic [7:0] d, output logic slot);
        int i;
        for (i = 7; i >= 0; i--)
            bit_x(1'b1, d[i]);
        bit_x(!ackIt, slot);
    endtask
endmodule

//--- verification/testbench.sv
`timescale 1ns/1ps

module testbench;
    localparam int WRITE_CYC = 400;
    localparam int LIMIT = 40000;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clkEn = 1'b1;
    logic sclLine;
    logic hostLow;
    logic transmitOnlyClock;
    logic sdaOut;
    logic sdaOe;
    logic bidirMode;
    logic writeBusy;
    wire logic sdaLine;
    int error_cnt = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [7:0] expQ[$];

    // Open-drain data line with a pull-up
    assign sdaLine = !((sdaOe && !sdaOut) || hostLow);

    dme_port #(.WRITE_CYCLES(WRITE_CYC)) u_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .clkEn(clkEn),
        .transmitOnlyClock(transmitOnlyClock), .sclIn(sclLine), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .bidirMode(bidirMode), .writeBusy(writeBusy)
    );

    dme_host_model u_host (
        .ref_clk(ref_clk), .sdaLine(sdaLine), .sclLine(sclLine), .sdaLow(hostLow),
        .transmitOnlyClock(transmitOnlyClock)
    );

    // Core clock, 100 MHz
    always #5 ref_clk = !ref_clk;

    // Hang guard: the whole run needs under half of this
    always @(posedge ref_clk)
    begin
        cycles = cycles + 1;
        if (cycles == LIMIT)
        begin
            error_cnt++;
            $display("[FAIL] %0t timeout", $time);
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cmp1(input logic got, input logic exp, input string msg);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t %s got %b exp %b", $time, msg, got, exp);
        end
    endtask

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // Link reset must see a few sync rises, so they run during reset
    task automatic do_reset();
        reset_n <= 1'b0;
        fork
            repeat (4) @(posedge ref_clk);
            u_host.pulse_sync(4);
        join
        @(posedge ref_clk) reset_n <= 1'b1;
    endtask

    // The pin follows a rise 30 to 40 ns late, so bit k is read 68 ns after rise k.
    // Memory is clear, so a data slot pulls low and a released slot does not.
    task automatic run_sync(input int n, input int skip);
        int k;
        @(posedge ref_clk);
        fork
            u_host.pulse_sync(n);
            begin
                #47;
                for (k = 1; k <= n; k++)
                begin
                    #48;
                    cmp1(sdaOe, k > skip && (k - skip - 1) % 9 != 8, "stream slot");
                end
            end
        join
    endtask

    task automatic wr_bytes(input logic [7:0] a, input logic [7:0] d0, input int n);
        logic ack;
        int i;
        u_host.start_cond();
        u_host.send_byte(8'hA0, ack);
        cmp1(ack, 1'b1, "write control ack");
        u_host.send_byte(a, ack);
        cmp1(ack, 1'b1, "word ack");
        for (i = 0; i < n; i++)
        begin
            u_host.send_byte(d0 + 8'(i), ack);
            cmp1(ack, 1'b1, "data ack");
        end
        u_host.stop_cond();
    endtask

    // Random read of expQ.size() bytes, last one left unacknowledged
    task automatic rd_bytes(input logic [7:0] a);
        logic ack;
        logic [7:0] d;
        int i;
        u_host.start_cond();
        u_host.send_byte(8'hA0, ack);
        u_host.send_byte(a, ack);
        u_host.start_cond();
        u_host.send_byte(8'hA1, ack);
        cmp1(ack, 1'b1, "read control ack");
        for (i = 0; i < expQ.size(); i++)
        begin
            u_host.recv_byte(i < expQ.size() - 1, d, ack);
            cmp8(d, expQ[i], "read data");
        end
        cmp1(ack, 1'b1, "line free after nack");
        u_host.stop_cond();
    endtask

    task automatic wait_idle();
        int i;
        for (i = 0; i < WRITE_CYC + 100 && writeBusy !== 1'b0; i++)
            @(posedge ref_clk);
        cmp1(writeBusy, 1'b0, "write cycle ends");
    endtask

    ////////////////////////////////////////////////////////////
    // Full lap of the lower half, the first byte again after the wrap, plus the sync slots
    task automatic t_stream();
        run_sync(1170, 9);
    endtask

    // Count restarts on each bus clock fall, then streaming resumes at MSB
    task automatic t_transition();
        u_host.wake();
        run_sync(100, 100);
        u_host.wake();
        run_sync(128, 128);
        run_sync(9, 0);
        cmp1(bidirMode, 1'b0, "mode after return");
    endtask

    task automatic t_bidir();
        logic ack;
        u_host.wake();
        u_host.start_cond();
        u_host.send_byte(8'hA2, ack);
        cmp1(ack, 1'b0, "foreign address");
        u_host.stop_cond();
        cmp1(bidirMode, 1'b0, "no lock on foreign byte");
        u_host.set_sync(1'b1);
        wr_bytes(8'h40, 8'h5A, 1);
        cmp1(bidirMode, 1'b1, "locked");
        cmp1(writeBusy, 1'b1, "write cycle runs");
        u_host.start_cond();
        u_host.send_byte(8'hA0, ack);
        cmp1(ack, 1'b0, "no ack while busy");
        u_host.stop_cond();
        wait_idle();
        expQ = '{8'h5A};
        rd_bytes(8'h40);
        wr_bytes(8'hF8, 8'h01, 10);
        wait_idle();
        expQ = '{8'h09, 8'h0A, 8'h03};
        rd_bytes(8'hF8);
        u_host.set_sync(1'b0);
        wr_bytes(8'h41, 8'h77, 1);
        u_host.set_sync(1'b1);
        wait_idle();
        expQ = '{8'h00};
        rd_bytes(8'h41);
        run_sync(20, 20);
        cmp1(bidirMode, 1'b1, "still locked");
    endtask

    // Main sequence
    initial
    begin
        do_reset();
        cmp1(sdaOe, 1'b0, "line free after reset");
        t_stream();
        t_transition();
        t_bidir();
        end_sim();
    end
endmodule
